/* File: include/memmap_pkg.sv */
// Address map, mode encodings and access-size constants for the memory glue
package memmap_pkg;

    // ****************************************
    // Access sizes
    // ****************************************
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0,
        SIZE_HALF = 2'h1,
        SIZE_WORD = 2'h2
    } access_size_t;

    // ****************************************
    // Mapping modes
    // ****************************************
    typedef enum logic [1:0] {
        MODE_BOOT = 2'h0,
        MODE_USER_FLASH = 2'h1,
        MODE_USER_RAM = 2'h2
    } map_mode_t;

    // ****************************************
    // Decoded regions, one-hot
    // ****************************************
    typedef enum logic [5:0] {
        REG_NONE = 6'h01,
        REG_FLASH = 6'h02,
        REG_SRAM = 6'h04,
        REG_BOOT = 6'h08,
        REG_PERIPH_LO = 6'h10,
        REG_PERIPH_HI = 6'h20
    } region_t;

    // ****************************************
    // Address map
    // ****************************************
    localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
    localparam logic [31:0] FLASH_BYTES = 32'h0008_0000;
    localparam logic [31:0] SRAM_BASE = 32'h4000_0000;
    localparam int SRAM_OFF_W = 13;
    localparam int SRAM_IDX_W = 11;
    localparam int SRAM_WORDS = 2048;
    localparam logic [31:0] BOOT_BASE = 32'h7FFF_E000;
    localparam int BOOT_OFF_W = 13;
    localparam logic [31:0] PERIPH_LO_BASE = 32'hE000_0000;
    localparam logic [31:0] PERIPH_HI_BASE = 32'hFFE0_0000;
    localparam int PERIPH_SPAN_LSB = 21;
    localparam int SLOT_LSB = 14;
    localparam int SLOT_W = 7;
    localparam logic [6:0] SLOT_SYSCTL = 7'h7F;
    localparam int OVERLAY_LSB = 6;
    localparam logic [1:0] WORD_ALIGN_CLR = 2'h0;

    // ****************************************
    // Exception vector word offsets
    // ****************************************
    localparam logic [31:0] VEC_RESET = 32'h0000_0000;
    localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
    localparam logic [31:0] VEC_SWI = 32'h0000_0008;
    localparam logic [31:0] VEC_PABORT = 32'h0000_000C;
    localparam logic [31:0] VEC_DABORT = 32'h0000_0010;
    localparam logic [31:0] VEC_PROG_KEY = 32'h0000_0014;
    localparam logic [31:0] VEC_IRQ = 32'h0000_0018;
    localparam logic [31:0] VEC_FIQ = 32'h0000_001C;
    localparam logic [31:0] OVERLAY_LAST = 32'h0000_003F;

endpackage : memmap_pkg

/* File: include/sram_req_if.sv */
// Request and read-data path between the decoder and the SRAM controller
`timescale 1ns/1ps
interface sram_req_if;
    import memmap_pkg::*;
    logic valid;
    logic write;
    access_size_t size;
    logic [SRAM_OFF_W-1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;

    modport master (output valid, output write, output size, output addr, output wdata, input rdata);
    modport slave (input valid, input write, input size, input addr, input wdata, output rdata);
endinterface : sram_req_if

/* File: hw/sram_ctrl.sv */
// SRAM array with size handling and a one-entry write-back buffer
`timescale 1ns/1ps
module sram_ctrl
    import memmap_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    sram_req_if.slave req
);

    // ****************************************
    // Lane helpers
    // ****************************************
    function automatic logic [3:0] lane_mask(input access_size_t sz, input logic [1:0] a);
        logic [3:0] m;
        m = 4'h0;
        unique case (sz)
            SIZE_BYTE: m = 4'h1 << a;
            SIZE_HALF: m = a[1] ? 4'hC : 4'h3;
            default: m = 4'hF;
        endcase
        return m;
    endfunction : lane_mask

    logic buf_valid_reg, buf_valid_next;
    logic [SRAM_IDX_W-1:0] buf_idx_reg, buf_idx_next;
    logic [31:0] buf_data_reg, buf_data_next;
    logic [3:0] buf_mask_reg, buf_mask_next;
    logic [31:0] mem [SRAM_WORDS];
    logic commit;
    logic [31:0] lane_data;
    logic [31:0] merged;
    logic [SRAM_IDX_W-1:0] idx;

    assign idx = req.addr[SRAM_OFF_W-1:2];

    // ****************************************
    // Write-back buffer
    // ****************************************
    always_comb begin
        buf_valid_next = buf_valid_reg;
        buf_idx_next = buf_idx_reg;
        buf_data_next = buf_data_reg;
        buf_mask_next = buf_mask_reg;
        commit = 1'b0;
        unique case (req.size)
            SIZE_BYTE: lane_data = {4{req.wdata[7:0]}};
            SIZE_HALF: lane_data = {2{req.wdata[15:0]}};
            default: lane_data = req.wdata;
        endcase
        if (req.valid && req.write) begin
            commit = buf_valid_reg;
            buf_valid_next = 1'b1;
            buf_idx_next = idx;
            buf_data_next = lane_data;
            buf_mask_next = lane_mask(req.size, req.addr[1:0]);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            buf_valid_reg <= 1'b0;
            buf_idx_reg <= '0;
            buf_data_reg <= 32'h0000_0000;
            buf_mask_reg <= 4'h0;
        end else begin
            buf_valid_reg <= buf_valid_next;
            buf_idx_reg <= buf_idx_next;
            buf_data_reg <= buf_data_next;
            buf_mask_reg <= buf_mask_next;
        end
    end

    // Array has no reset: its contents survive a warm reset
    // One process owns the whole array, so lanes never count as rival drivers
    always_ff @(posedge clk_sys) begin
        for (int l = 0; l < 4; l++) begin
            if (commit && buf_mask_reg[l]) begin
                mem[buf_idx_reg][8*l +: 8] <= buf_data_reg[8*l +: 8];
            end
        end
    end

    for (genvar l = 0; l < 4; l++) begin : g_lane
        // Pending buffer bytes are forwarded so reads never see stale data
        assign merged[8*l +: 8] = (buf_valid_reg && buf_idx_reg == idx && buf_mask_reg[l])
            ? buf_data_reg[8*l +: 8] : mem[idx][8*l +: 8];
    end

    // ****************************************
    // Read extraction, zero extended
    // ****************************************
    always_comb begin
        unique case (req.size)
            SIZE_BYTE: req.rdata = {24'h00_0000, merged[8*req.addr[1:0] +: 8]};
            SIZE_HALF: req.rdata = {16'h0000, (req.addr[1] ? merged[31:16] : merged[15:0])};
            default: req.rdata = merged;
        endcase
    end

endmodule : sram_ctrl

/* File: hw/memmap_top.sv */
// Address decoder, vector overlay and mode control in front of the on-chip memories
// Notes on behaviour
// - SRAM takes byte, halfword and word accesses
// - Low address bits ignored for wider accesses
// - Last write held until next write
// - Reset does not flush the pending write
// - Peripheral regions: 128 slots of 16 kB
// - Peripheral addresses are word aligned, access size passed through
// - System control sits in top slot of the low peripheral region
// - Eight vector words from address zero
// - Every reset selects boot-loader mapping
// - User flash mode applies no overlay
// - User RAM mode overlays bottom of SRAM
// - Overlay spans 64 bytes from zero
// - Remapped areas stay at native address
// - Boot block fixed at top of on-chip space
// - All other regions keep fixed ranges
`timescale 1ns/1ps
module memmap_top
    import memmap_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire memmap_pkg::access_size_t req_size,
    input wire logic [31:0] req_addr,
    input wire logic [31:0] req_wdata,
    input wire logic mode_wr,
    input wire memmap_pkg::map_mode_t mode_wdata,
    output logic rsp_valid,
    output logic [31:0] rsp_rdata,
    output logic ext_valid,
    output memmap_pkg::region_t ext_region,
    output logic [31:0] ext_addr,
    output logic ext_write,
    output memmap_pkg::access_size_t ext_size,
    output logic [31:0] ext_wdata,
    output logic [6:0] periph_slot,
    output logic sysctl_sel,
    output logic unmapped,
    output memmap_pkg::map_mode_t map_mode
);

    // ****************************************
    // Region decode
    // ****************************************
    // boot block fixed location
    function automatic region_t region_of(input logic [31:0] a);
        region_t r;
        r = REG_NONE;
        if (a < FLASH_BASE + FLASH_BYTES) begin
            r = REG_FLASH;
        end else if (a[31:SRAM_OFF_W] == SRAM_BASE[31:SRAM_OFF_W]) begin
            r = REG_SRAM;
        end else if (a[31:BOOT_OFF_W] == BOOT_BASE[31:BOOT_OFF_W]) begin
            r = REG_BOOT;
        end else if (a[31:PERIPH_SPAN_LSB] == PERIPH_LO_BASE[31:PERIPH_SPAN_LSB]) begin
            r = REG_PERIPH_LO;
        end else if (a[31:PERIPH_SPAN_LSB] == PERIPH_HI_BASE[31:PERIPH_SPAN_LSB]) begin
            r = REG_PERIPH_HI;
        end
        return r;
    endfunction : region_of

    sram_req_if sram_bus ();

    map_mode_t mode_reg, mode_next;
    logic rsp_valid_reg, rsp_valid_next;
    logic [31:0] rsp_rdata_reg, rsp_rdata_next;
    logic ext_valid_reg, ext_valid_next;
    region_t ext_region_reg, ext_region_next;
    logic [31:0] ext_addr_reg, ext_addr_next;
    logic ext_write_reg, ext_write_next;
    access_size_t ext_size_reg, ext_size_next;
    logic [31:0] ext_wdata_reg, ext_wdata_next;
    logic [6:0] slot_reg, slot_next;
    logic sysctl_reg, sysctl_next;
    logic unmapped_reg, unmapped_next;
    logic [31:0] eff_addr;
    region_t region;
    logic in_overlay;

    // ****************************************
    // Mode control
    // ****************************************
    always_comb begin
        mode_next = mode_reg;
        if (mode_wr && (mode_wdata == MODE_BOOT || mode_wdata == MODE_USER_FLASH
                        || mode_wdata == MODE_USER_RAM)) begin
            mode_next = mode_wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_reg <= MODE_BOOT;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // ****************************************
    // Vector overlay
    // ****************************************
    always_comb begin
        in_overlay = (req_addr[31:OVERLAY_LSB] == OVERLAY_LAST[31:OVERLAY_LSB]);
        eff_addr = req_addr;
        if (in_overlay) begin
            unique case (mode_reg)
                MODE_BOOT: eff_addr = {BOOT_BASE[31:OVERLAY_LSB], req_addr[OVERLAY_LSB-1:0]};
                MODE_USER_RAM: eff_addr = {SRAM_BASE[31:OVERLAY_LSB], req_addr[OVERLAY_LSB-1:0]};
                default: eff_addr = req_addr;
            endcase
        end
        region = region_of(eff_addr);
    end

    // ****************************************
    // SRAM request
    // ****************************************
    always_comb begin
        sram_bus.valid = req_valid && (region == REG_SRAM);
        sram_bus.write = req_write;
        sram_bus.size = req_size;
        sram_bus.addr = eff_addr[SRAM_OFF_W-1:0];
        sram_bus.wdata = req_wdata;
    end

    sram_ctrl u_sram (
        .clk_sys(clk_sys),
        .rst(rst),
        .req(sram_bus.slave)
    );

    // ****************************************
    // Response and forwarded access
    // ****************************************
    always_comb begin
        rsp_valid_next = 1'b0;
        rsp_rdata_next = rsp_rdata_reg;
        ext_valid_next = 1'b0;
        ext_region_next = ext_region_reg;
        ext_addr_next = ext_addr_reg;
        ext_write_next = ext_write_reg;
        ext_size_next = ext_size_reg;
        ext_wdata_next = ext_wdata_reg;
        slot_next = slot_reg;
        sysctl_next = 1'b0;
        unmapped_next = 1'b0;
        if (req_valid) begin
            if (region == REG_SRAM) begin
                rsp_valid_next = 1'b1;
                // Writes answer at once; the buffer hides the array write
                rsp_rdata_next = req_write ? 32'h0000_0000 : sram_bus.rdata;
            end else if (region == REG_NONE) begin
                // Abort signalling lives in the core; only a flag here
                unmapped_next = 1'b1;
            end else begin
                ext_valid_next = 1'b1;
                ext_region_next = region;
                ext_addr_next = eff_addr;
                ext_write_next = req_write;
                ext_size_next = req_size;
                ext_wdata_next = req_wdata;
                if (region == REG_PERIPH_LO || region == REG_PERIPH_HI) begin
                    ext_addr_next = {eff_addr[31:2], WORD_ALIGN_CLR};
                    slot_next = eff_addr[SLOT_LSB +: SLOT_W];
                    sysctl_next = (region == REG_PERIPH_LO)
                        && (eff_addr[SLOT_LSB +: SLOT_W] == SLOT_SYSCTL);
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= 32'h0000_0000;
            ext_valid_reg <= 1'b0;
            ext_region_reg <= REG_NONE;
            ext_addr_reg <= 32'h0000_0000;
            ext_write_reg <= 1'b0;
            ext_size_reg <= SIZE_WORD;
            ext_wdata_reg <= 32'h0000_0000;
            slot_reg <= 7'h00;
            sysctl_reg <= 1'b0;
            unmapped_reg <= 1'b0;
        end else begin
            rsp_valid_reg <= rsp_valid_next;
            rsp_rdata_reg <= rsp_rdata_next;
            ext_valid_reg <= ext_valid_next;
            ext_region_reg <= ext_region_next;
            ext_addr_reg <= ext_addr_next;
            ext_write_reg <= ext_write_next;
            ext_size_reg <= ext_size_next;
            ext_wdata_reg <= ext_wdata_next;
            slot_reg <= slot_next;
            sysctl_reg <= sysctl_next;
            unmapped_reg <= unmapped_next;
        end
    end

    assign rsp_valid = rsp_valid_reg;
    assign rsp_rdata = rsp_rdata_reg;
    assign ext_valid = ext_valid_reg;
    assign ext_region = ext_region_reg;
    assign ext_addr = ext_addr_reg;
    assign ext_write = ext_write_reg;
    assign ext_size = ext_size_reg;
    assign ext_wdata = ext_wdata_reg;
    assign periph_slot = slot_reg;
    assign sysctl_sel = sysctl_reg;
    assign unmapped = unmapped_reg;
    assign map_mode = mode_reg;

endmodule : memmap_top

/* File: sim/memmap_chk.sv */
// Concurrent checks on the memory glue top-level ports
`timescale 1ns/1ps
module memmap_chk
    import memmap_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic [31:0] req_addr,
    input wire logic mode_wr,
    input wire memmap_pkg::map_mode_t mode_wdata,
    input wire logic rsp_valid,
    input wire logic ext_valid,
    input wire memmap_pkg::region_t ext_region,
    input wire logic [31:0] ext_addr,
    input wire logic [6:0] periph_slot,
    input wire logic sysctl_sel,
    input wire logic unmapped,
    input wire memmap_pkg::map_mode_t map_mode
);
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_sram_answer: assert property (
        req_valid && req_addr[31:SRAM_OFF_W] == SRAM_BASE[31:SRAM_OFF_W] |=> rsp_valid && !ext_valid)
        else $error("SRAM access not answered");
    a_periph_slot: assert property (
        req_valid && req_addr[31:21] == PERIPH_LO_BASE[31:21]
        |=> ext_valid && ext_region == REG_PERIPH_LO && periph_slot == $past(req_addr[20:14]))
        else $error("peripheral slot wrong");
    a_periph_align: assert property (
        ext_valid && (ext_region == REG_PERIPH_LO || ext_region == REG_PERIPH_HI)
        |-> ext_addr == {$past(req_addr[31:2]), 2'h0}) else $error("peripheral address not word aligned");
    a_sysctl_slot: assert property (
        req_valid && req_addr[31:14] == {PERIPH_LO_BASE[31:21], SLOT_SYSCTL} |=> sysctl_sel)
        else $error("system control slot not selected");
    a_boot_overlay: assert property (
        req_valid && req_addr[31:6] == 26'h0 && map_mode == MODE_BOOT
        |=> ext_valid && ext_region == REG_BOOT && ext_addr == BOOT_BASE + $past(req_addr))
        else $error("boot overlay wrong");
    a_flash_direct: assert property (
        req_valid && req_addr[31:6] == 26'h0 && map_mode == MODE_USER_FLASH
        |=> ext_region == REG_FLASH && ext_addr == $past(req_addr)) else $error("flash vectors remapped");
    a_ram_overlay: assert property (
        req_valid && req_addr[31:6] == 26'h0 && map_mode == MODE_USER_RAM |=> rsp_valid && !ext_valid)
        else $error("RAM overlay not served by SRAM");
    a_overlay_end: assert property (
        req_valid && req_addr[31:6] == 26'h1 |=> ext_valid && ext_region == REG_FLASH)
        else $error("overlay wider than 64 bytes");
    a_boot_native: assert property (
        req_valid && req_addr[31:13] == BOOT_BASE[31:13] |=> ext_region == REG_BOOT && ext_addr == $past(req_addr))
        else $error("boot block not at native address");
    a_mode_reset: assert property (
        disable iff (1'b0) rst |=> map_mode == MODE_BOOT) else $error("reset did not select boot mode");
    a_mode_load: assert property (
        mode_wr |=> map_mode == ($past(mode_wdata) == 2'h3 ? $past(map_mode) : $past(mode_wdata)))
        else $error("mode write wrong");
    a_unmapped_flag: assert property (
        req_valid && req_addr[31:28] == 4'h9 |=> unmapped && !ext_valid && !rsp_valid)
        else $error("hole not flagged");
endmodule : memmap_chk

/* File: sim/core_model.sv */
// Processor-side request driver for the memory glue
`timescale 1ns/1ps
module core_model
    import memmap_pkg::*;
(
    input wire logic clk_sys,
    output logic req_valid,
    output logic req_write,
    output memmap_pkg::access_size_t req_size,
    output logic [31:0] req_addr,
    output logic [31:0] req_wdata,
    output logic mode_wr,
    output memmap_pkg::map_mode_t mode_wdata
);
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_size = SIZE_WORD;
        req_addr = 32'h0;
        req_wdata = 32'h0;
        mode_wr = 1'b0;
        mode_wdata = MODE_BOOT;
    end
    // any size, address as given
    // One access per call; valid drops and address and data are inverted once released so stale values never look valid
    task automatic acc(input logic wr, input access_size_t sz, input logic [31:0] a, input logic [31:0] d);
        @(negedge clk_sys);
        req_valid = 1'b1;
        req_write = wr;
        req_size = sz;
        req_addr = a;
        req_wdata = d;
        @(negedge clk_sys);
        req_valid = 1'b0;
        req_addr = ~a;
        req_wdata = ~d;
    endtask : acc
    task automatic flush(input logic [31:0] a, input logic [31:0] d);
        acc(1'b1, SIZE_WORD, a, d);
        acc(1'b1, SIZE_WORD, a, d);
    endtask : flush
    task automatic set_mode(input map_mode_t m);
        @(negedge clk_sys);
        mode_wr = 1'b1;
        mode_wdata = m;
        @(negedge clk_sys);
        mode_wr = 1'b0;
    endtask : set_mode
endmodule : core_model

/* File: sim/tb.sv */
// Self-checking bench for the memory glue
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
module tb;
    import memmap_pkg::*;
    typedef struct {logic wr; access_size_t sz; logic [31:0] a; logic [31:0] d; logic [31:0] exp;} row_t;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic req_valid, req_write, mode_wr, rsp_valid, ext_valid, ext_write, sysctl_sel, unmapped;
    access_size_t req_size, ext_size;
    map_mode_t mode_wdata, map_mode;
    region_t ext_region;
    logic [31:0] req_addr, req_wdata, rsp_rdata, ext_addr, ext_wdata;
    logic [6:0] periph_slot;
    int error_cnt = 0;
    int checks_done = 0;
    // ****************************************
    // SRAM rows: forwarding, lanes, alignment
    // ****************************************
    row_t rows [10] = '{
        '{1'b1, SIZE_WORD, 32'h4000_0010, 32'h1122_3344, 32'h0}, '{1'b0, SIZE_WORD, 32'h4000_0012, 32'h0, 32'h1122_3344},
        '{1'b1, SIZE_BYTE, 32'h4000_0013, 32'h0000_00AB, 32'h0}, '{1'b0, SIZE_HALF, 32'h4000_0013, 32'h0, 32'h0000_AB22},
        '{1'b0, SIZE_BYTE, 32'h4000_0011, 32'h0, 32'h0000_0033}, '{1'b1, SIZE_HALF, 32'h4000_0017, 32'h0000_5566, 32'h0},
        '{1'b0, SIZE_HALF, 32'h4000_0016, 32'h0, 32'h0000_5566}, '{1'b0, SIZE_WORD, 32'h4000_0010, 32'h0, 32'hAB22_3344},
        '{1'b1, SIZE_WORD, 32'h4000_1FFF, 32'hCAFE_F00D, 32'h0}, '{1'b0, SIZE_BYTE, 32'h4000_1FFE, 32'h0, 32'h0000_00FE}};
    always #10 clk_sys = ~clk_sys;
    core_model u_core (.clk_sys(clk_sys), .req_valid(req_valid), .req_write(req_write), .req_size(req_size),
        .req_addr(req_addr), .req_wdata(req_wdata), .mode_wr(mode_wr), .mode_wdata(mode_wdata));
    memmap_top u_dut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_write(req_write),
        .req_size(req_size), .req_addr(req_addr), .req_wdata(req_wdata), .mode_wr(mode_wr),
        .mode_wdata(mode_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ext_valid(ext_valid),
        .ext_region(ext_region), .ext_addr(ext_addr), .ext_write(ext_write), .ext_size(ext_size),
        .ext_wdata(ext_wdata), .periph_slot(periph_slot), .sysctl_sel(sysctl_sel), .unmapped(unmapped),
        .map_mode(map_mode));
    task automatic print_verdict();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    task automatic ext_chk(input region_t r, input logic [31:0] a);
        `CHK(ext_valid, 1'b1)
        `CHK(ext_region, r)
        `CHK(ext_addr, a)
    endtask : ext_chk
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        u_core.acc(1'b0, SIZE_WORD, a, 32'h0);
        `CHK(rsp_valid, 1'b1)
        `CHK(rsp_rdata, exp)
    endtask : rd_chk
    task automatic warm_reset();
        @(negedge clk_sys);
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
    endtask : warm_reset
    // Hang guard: everything here has fixed latency, so a long run means a stuck task
    initial begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        `CHK(map_mode, MODE_BOOT)
        foreach (rows[i]) begin
            u_core.acc(rows[i].wr, rows[i].sz, rows[i].a, rows[i].d);
            `CHK(rsp_valid, 1'b1)
            `CHK(rsp_rdata, rows[i].exp)
        end
        // ****************************************
        // Overlay edges in every mode
        // ****************************************
        for (int m = 0; m < 3; m++) begin
            u_core.set_mode(map_mode_t'(m));
            u_core.acc(1'b0, SIZE_WORD, 32'h0000_003C, 32'h0);
            if (m == 2) `CHK(rsp_valid, 1'b1)
            else ext_chk(m == 0 ? REG_BOOT : REG_FLASH, m == 0 ? 32'h7FFF_E03C : 32'h0000_003C);
            u_core.acc(1'b0, SIZE_WORD, 32'h0000_0040, 32'h0);
            ext_chk(REG_FLASH, 32'h0000_0040);
        end
        u_core.acc(1'b1, SIZE_WORD, 32'h4000_0004, 32'h600D_F00D);
        rd_chk(32'h0000_0004, 32'h600D_F00D);
        rd_chk(32'h4000_0004, 32'h600D_F00D);
        u_core.set_mode(map_mode_t'(2'h3));
        `CHK(map_mode, MODE_USER_RAM)
        u_core.set_mode(MODE_BOOT);
        u_core.acc(1'b0, SIZE_WORD, 32'h0000_0014, 32'h0);
        ext_chk(REG_BOOT, 32'h7FFF_E014);
        u_core.acc(1'b0, SIZE_WORD, 32'h7FFF_E014, 32'h0);
        ext_chk(REG_BOOT, 32'h7FFF_E014);
        u_core.set_mode(MODE_USER_FLASH);
        u_core.acc(1'b0, SIZE_WORD, 32'h0000_0014, 32'h0);
        ext_chk(REG_FLASH, 32'h0000_0014);
        // ****************************************
        // Peripheral slots and holes
        // ****************************************
        u_core.acc(1'b0, SIZE_HALF, 32'hE01F_C042, 32'h0);
        ext_chk(REG_PERIPH_LO, 32'hE01F_C040);
        `CHK({ext_write, ext_size}, {1'b0, SIZE_HALF})
        `CHK({periph_slot, sysctl_sel}, {SLOT_SYSCTL, 1'b1})
        u_core.acc(1'b1, SIZE_WORD, 32'hE007_0000, 32'h0000_0001);
        `CHK({ext_region, periph_slot, sysctl_sel}, {REG_PERIPH_LO, 7'h1C, 1'b0})
        `CHK({ext_write, ext_size, ext_wdata}, {1'b1, SIZE_WORD, 32'h0000_0001})
        u_core.acc(1'b0, SIZE_WORD, 32'hFFE0_4000, 32'h0);
        `CHK({ext_region, periph_slot, sysctl_sel}, {REG_PERIPH_HI, 7'h01, 1'b0})
        u_core.acc(1'b0, SIZE_WORD, 32'h9000_0000, 32'h0);
        `CHK({unmapped, ext_valid, rsp_valid}, 3'h4)
        // ****************************************
        // Warm reset leaves the pending write out
        // ****************************************
        u_core.acc(1'b1, SIZE_WORD, 32'h4000_0034, 32'hC0C0_C0C0);
        u_core.acc(1'b1, SIZE_WORD, 32'h4000_0038, 32'h0);
        u_core.acc(1'b1, SIZE_WORD, 32'h4000_0034, 32'hB0B0_B0B0);
        u_core.set_mode(MODE_USER_FLASH);
        warm_reset();
        `CHK(map_mode, MODE_BOOT)
        rd_chk(32'h4000_0034, 32'hC0C0_C0C0);
        u_core.flush(32'h4000_0034, 32'hB0B0_B0B0);
        warm_reset();
        rd_chk(32'h4000_0034, 32'hB0B0_B0B0);
        print_verdict();
    end
endmodule : tb
bind memmap_top memmap_chk u_chk (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_addr(req_addr),
    .mode_wr(mode_wr), .mode_wdata(mode_wdata), .rsp_valid(rsp_valid), .ext_valid(ext_valid),
    .ext_region(ext_region), .ext_addr(ext_addr), .periph_slot(periph_slot), .sysctl_sel(sysctl_sel),
    .unmapped(unmapped), .map_mode(map_mode));
